/* File: core/tws_pkg.sv */
package tws_pkg;

  // Register indices; the byte address of each register is four times it.
  localparam logic [15:0] TWS_IDX_PORT1_DIR   = 16'hFF21;
  localparam logic [15:0] TWS_IDX_PORT1_LATCH = 16'hFF01;
  localparam logic [15:0] TWS_IDX_MODE        = 16'hFF80;
  localparam logic [15:0] TWS_IDX_CLK_SEL     = 16'hFF81;
  localparam logic [15:0] TWS_IDX_TX_BUF      = 16'hFF82;
  localparam logic [15:0] TWS_IDX_SHIFT       = 16'hFF83;
  localparam logic [15:0] TWS_IDX_STATUS      = 16'hFF84;

  localparam int TWS_ADDR_W = 18;

  // Mode register fields.
  localparam int TWS_MODE_EN   = 7;
  localparam int TWS_MODE_TRMD = 6;
  localparam int TWS_MODE_DIR  = 4;
  localparam int TWS_MODE_BUSY = 0;
  // Clock select register fields.
  localparam int TWS_CS_CKP    = 4;
  localparam int TWS_CS_DAP    = 3;
  localparam int TWS_CS_SRC_HI = 2;
  // Status register field.
  localparam int TWS_ST_DONE   = 0;

  // Port 1 pin positions.
  localparam int TWS_PIN_SCK = 0;
  localparam int TWS_PIN_SO  = 2;

  localparam logic [7:0] TWS_MODE_RST  = 8'h00;
  localparam logic [7:0] TWS_CS_RST    = 8'h00;
  localparam logic [7:0] TWS_DIR_RST   = 8'hFF;
  localparam logic [7:0] TWS_LATCH_RST = 8'h00;
  localparam logic [2:0] TWS_SRC_EXT   = 3'h7;
  localparam logic [4:0] TWS_EDGES     = 5'h10;

  typedef enum logic {TWS_IDLE, TWS_RUN} tws_state_t;

  typedef struct packed {
    logic en;
    logic trmd;
    logic dir;
  } tws_mode_t;

  typedef struct packed {
    logic       ckp;
    logic       dap;
    logic [2:0] src;
  } tws_clk_t;

endpackage

/* File: core/tws_clkdiv.sv */
`timescale 1ns/100ps
`default_nettype none
module tws_clkdiv
  import tws_pkg::*;
#(
  parameter int DIV_W = 7
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output var  logic       tick
);

  if (DIV_W < 7) begin : g_div_w_check
    $error("tws_clkdiv: DIV_W must cover division by 128");
  end

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic [DIV_W-1:0] mask;
  logic             tick_d;

  // Half a serial clock period lasts 2**sel peripheral clocks.
  always_comb begin
    mask   = DIV_W'((1 << sel) - 1);
    tick_d = run && ((cnt_q & mask) == mask);
    cnt_d  = run ? cnt_q + DIV_W'(1) : '0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end

endmodule
`default_nettype wire

/* File: core/tws_top.sv */
// Chosen here: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module tws_top
  import tws_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic [TWS_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output var  logic [31:0]           avs_readdata,
  output var  logic                  avs_waitrequest,
  input  wire logic                  serial_clock_pin_i,
  input  wire logic                  serial_data_in_pin_i,
  output var  logic [7:0]            port1_out,
  output var  logic [7:0]            port1_oe,
  output var  logic                  transfer_done_irq_flag
);

  function automatic logic [TWS_ADDR_W-1:0] byte_addr(logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  // Register state.
  tws_mode_t  mode_q, mode_d;
  tws_clk_t   csel_q, csel_d;
  logic [7:0] dir_q, dir_d;
  logic [7:0] latch_q, latch_d;
  logic [7:0] txbuf_q, txbuf_d;
  logic       done_q, done_d;
  logic       wait_d;
  logic [31:0] rdata_d;

  // Transfer state.
  tws_state_t st_q, st_d;
  logic [7:0] sh_q, sh_d;
  logic [4:0] edges_q, edges_d;
  logic       sck_q, sck_d;
  logic       so_q, so_d;
  logic [7:0] pout_d, poe_d;

  // Pin synchronisers; a change counts once stages two and three agree.
  logic [2:0] sck_sync_q, si_sync_q;
  logic       sck_f_q, si_f_q;

  logic acc, wr_acc, rd_acc, be0;
  logic master, busy, tick, lead, trail, ev;

  always_ff @(posedge clk) begin
    if (srst) begin
      sck_sync_q <= '1;
      si_sync_q  <= '0;
      sck_f_q    <= 1'b1;
      si_f_q     <= 1'b0;
    end else begin
      sck_sync_q <= {sck_sync_q[1:0], serial_clock_pin_i};
      si_sync_q  <= {si_sync_q[1:0], serial_data_in_pin_i};
      if (sck_sync_q[1] == sck_sync_q[2]) begin
        sck_f_q <= sck_sync_q[2];
      end
      if (si_sync_q[1] == si_sync_q[2]) begin
        si_f_q <= si_sync_q[2];
      end
    end
  end

  assign busy   = (st_q == TWS_RUN);
  assign master = (csel_q.src != TWS_SRC_EXT);
  assign acc    = (avs_read || avs_write) && !avs_waitrequest;
  assign wr_acc = acc && avs_write;
  assign rd_acc = acc && avs_read;
  assign be0    = avs_byteenable[0];

  tws_clkdiv #(
    .DIV_W (7)
  ) u_div (
    .clk  (clk),
    .srst (srst),
    .run  (busy && master),
    .sel  (csel_q.src),
    .tick (tick)
  );

  // Edge events: lead leaves the idle level, which is the inverse of polarity.
  always_comb begin
    if (master) begin
      ev = tick;
    end else begin
      ev = (sck_f_q != sck_q);
    end
    lead  = busy && ev && (sck_q == !csel_q.ckp);
    trail = busy && ev && (sck_q != !csel_q.ckp);
  end

  // Register file with one wait state per access.
  always_comb begin
    mode_d  = mode_q;
    csel_d  = csel_q;
    dir_d   = dir_q;
    latch_d = latch_q;
    txbuf_d = txbuf_q;
    done_d  = done_q;
    wait_d  = !((avs_read || avs_write) && avs_waitrequest);
    rdata_d = '0;
    if (wr_acc && be0) begin
      case (avs_address)
        byte_addr(TWS_IDX_MODE): begin
          mode_d.en   = avs_writedata[TWS_MODE_EN];
          mode_d.trmd = avs_writedata[TWS_MODE_TRMD];
          mode_d.dir  = avs_writedata[TWS_MODE_DIR];
        end
        byte_addr(TWS_IDX_CLK_SEL): begin
          csel_d.ckp = avs_writedata[TWS_CS_CKP];
          csel_d.dap = avs_writedata[TWS_CS_DAP];
          csel_d.src = avs_writedata[TWS_CS_SRC_HI:0];
        end
        byte_addr(TWS_IDX_PORT1_DIR):   dir_d   = avs_writedata[7:0];
        byte_addr(TWS_IDX_PORT1_LATCH): latch_d = avs_writedata[7:0];
        byte_addr(TWS_IDX_TX_BUF):      txbuf_d = avs_writedata[7:0];
        byte_addr(TWS_IDX_STATUS): begin
          if (avs_writedata[TWS_ST_DONE]) begin
            done_d = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (st_q == TWS_RUN && edges_d == TWS_EDGES) begin
      done_d = 1'b1;
    end
    if (avs_read && avs_waitrequest) begin
      case (avs_address)
        byte_addr(TWS_IDX_MODE): begin
          rdata_d[TWS_MODE_EN]   = mode_q.en;
          rdata_d[TWS_MODE_TRMD] = mode_q.trmd;
          rdata_d[TWS_MODE_DIR]  = mode_q.dir;
          rdata_d[TWS_MODE_BUSY] = busy;
        end
        byte_addr(TWS_IDX_CLK_SEL): begin
          rdata_d[TWS_CS_CKP]        = csel_q.ckp;
          rdata_d[TWS_CS_DAP]        = csel_q.dap;
          rdata_d[TWS_CS_SRC_HI:0]   = csel_q.src;
        end
        byte_addr(TWS_IDX_PORT1_DIR):   rdata_d[7:0] = dir_q;
        byte_addr(TWS_IDX_PORT1_LATCH): rdata_d[7:0] = latch_q;
        byte_addr(TWS_IDX_TX_BUF):      rdata_d[7:0] = txbuf_q;
        byte_addr(TWS_IDX_SHIFT):       rdata_d[7:0] = sh_q;
        byte_addr(TWS_IDX_STATUS):      rdata_d[TWS_ST_DONE] = done_q;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q          <= tws_mode_t'(3'h0);
      csel_q          <= tws_clk_t'(5'h00);
      dir_q           <= TWS_DIR_RST;
      latch_q         <= TWS_LATCH_RST;
      txbuf_q         <= 8'h00;
      done_q          <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      mode_q          <= mode_d;
      csel_q          <= csel_d;
      dir_q           <= dir_d;
      latch_q         <= latch_d;
      txbuf_q         <= txbuf_d;
      done_q          <= done_d;
      avs_waitrequest <= wait_d;
      avs_readdata    <= rdata_d;
    end
  end

  // Transfer engine.
  logic start, top_bit;
  logic [7:0] sh_in;
  always_comb begin
    start = mode_q.en && !busy &&
            ((wr_acc && be0 && avs_address == byte_addr(TWS_IDX_TX_BUF) &&
              mode_q.trmd) ||
             (rd_acc && avs_address == byte_addr(TWS_IDX_SHIFT) &&
              !mode_q.trmd));
    top_bit = mode_q.dir ? sh_q[0] : sh_q[7];
    sh_in   = mode_q.dir ? {si_f_q, sh_q[7:1]} : {sh_q[6:0], si_f_q};
    st_d    = st_q;
    sh_d    = sh_q;
    edges_d = edges_q;
    sck_d   = master ? sck_q : sck_f_q;
    so_d    = so_q;
    case (st_q)
      TWS_IDLE: begin
        if (master) begin
          sck_d = !csel_q.ckp;
        end
        if (start) begin
          st_d    = TWS_RUN;
          edges_d = '0;
          if (wr_acc) begin
            sh_d = txbuf_d;
            if (csel_q.dap) begin
              so_d = mode_q.dir ? txbuf_d[0] : txbuf_d[7];
            end
          end
        end
      end
      TWS_RUN: begin
        if (ev) begin
          edges_d = edges_q + 5'h01;
          if (master) begin
            sck_d = !sck_q;
          end
        end
        // Output on one edge, sample on the opposite one.
        if ((lead && !csel_q.dap) ||
            (trail && csel_q.dap && edges_d != TWS_EDGES)) begin
          so_d = mode_q.trmd ? top_bit : so_q;
        end
        if ((trail && !csel_q.dap) || (lead && csel_q.dap)) begin
          sh_d = sh_in;
        end
        if (edges_d == TWS_EDGES) begin
          st_d = TWS_IDLE;
        end
      end
      default: st_d = TWS_IDLE;
    endcase
    if (!mode_q.en) begin
      st_d    = TWS_IDLE;
      sh_d    = 8'h00;
      edges_d = '0;
      so_d    = 1'b0;
    end
  end

  // Pin multiplexing: the serial function takes a pin only while enabled.
  always_comb begin
    pout_d = latch_q;
    poe_d  = ~dir_q;
    if (mode_q.en && master) begin
      pout_d[TWS_PIN_SCK] = sck_q;
    end
    if (mode_q.en && mode_q.trmd) begin
      pout_d[TWS_PIN_SO] = so_q | latch_q[TWS_PIN_SO];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q      <= TWS_IDLE;
      sh_q      <= 8'h00;
      edges_q   <= 5'h00;
      sck_q     <= 1'b1;
      so_q      <= 1'b0;
      port1_out <= TWS_LATCH_RST;
      port1_oe  <= 8'h00;
      transfer_done_irq_flag <= 1'b0;
    end else begin
      st_q      <= st_d;
      sh_q      <= sh_d;
      edges_q   <= edges_d;
      sck_q     <= sck_d;
      so_q      <= so_d;
      port1_out <= pout_d;
      port1_oe  <= poe_d;
      transfer_done_irq_flag <= done_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_STOP_CLEARS: assert property (!mode_q.en |=> !busy && sh_q == 8'h00)
    else $error("disable did not clear busy or shift");
  // Checked at the first edge after release, where the disable is off.
  AST_RESET_PHASE: assert property ($fell(srst) |-> !csel_q.ckp &&
                                    !csel_q.dap && dir_q == TWS_DIR_RST)
    else $error("reset phase or direction wrong");
  AST_DIR_OE: assert property (##1 port1_oe == ~$past(dir_q))
    else $error("pin enable does not follow direction");
  AST_TX_START: assert property (mode_q.en && mode_q.trmd && !busy &&
      wr_acc && be0 && avs_address == byte_addr(TWS_IDX_TX_BUF) |=> busy)
    else $error("buffer write did not start transfer");
  AST_RX_START: assert property (mode_q.en && !mode_q.trmd && !busy &&
      rd_acc && avs_address == byte_addr(TWS_IDX_SHIFT) |=> busy)
    else $error("shift read did not start reception");
  AST_DONE_FLAG: assert property ($fell(busy) && mode_q.en |-> done_q)
    else $error("completion did not set done flag");
  AST_HOLD_LAST: assert property (!busy && $past(!busy) && mode_q.en
                                  |-> $stable(so_q))
    else $error("data out changed while idle");
  AST_DIV_TWO: assert property (tick && csel_q.src == 3'h1 && busy
                                |=> !tick)
    else $error("divide by four ticked twice in a row");
  AST_PORT_STOP: assert property (!mode_q.en |=> port1_out ==
                                  $past(latch_q))
    else $error("stopped pins not on port latch");
  AST_RX_SO_PORT: assert property (!mode_q.trmd |=> port1_out[TWS_PIN_SO]
                                   == $past(latch_q[TWS_PIN_SO]))
    else $error("receive-only drove data out");

  COV_MASTER_TX: cover property (busy && master && mode_q.trmd ##1 !busy);
  COV_SLAVE_RX: cover property (busy && !master && !mode_q.trmd ##1 !busy);
  COV_ABORT: cover property (busy && !mode_q.en);

endmodule
`default_nettype wire

/* File: verif/tws_peer.sv */
`timescale 1ns/100ps
`default_nettype none
module tws_peer (
  input  wire logic       dev_sck,
  input  wire logic       dev_so,
  input  wire logic       ext_mode,
  input  wire logic       lsb,
  input  wire logic [7:0] tx,
  output var  logic       ext_sck,
  output var  logic       so,
  output var  logic [7:0] rx
);
  logic       sck;
  logic [2:0] n;
  assign sck = ext_mode ? ext_sck : dev_sck;
  initial begin
    ext_sck = 1'b1;
    so = 1'b0;
    rx = 8'h00;
    n = 3'h0;
  end
  task automatic sync(input logic b);
    n = 3'h0;
    so = b;
  endtask
  // The clock rests high and is only run once the unit is enabled.
  task automatic frame(input int half);
    repeat (8) begin
      #half ext_sck = 1'b0;
      #half ext_sck = 1'b1;
    end
  endtask
  // Out on the falling edge, in on the rising edge.
  always @(negedge sck) begin
    so <= lsb ? tx[n] : tx[3'h7 - n];
  end
  always @(posedge sck) begin
    rx <= lsb ? {dev_so, rx[7:1]} : {rx[6:0], dev_so};
    n <= n + 3'h1;
  end
endmodule
`default_nettype wire

/* File: verif/tws_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  num_errors++; $display("Error at %0t: got %h exp %h", $time, a, b); end end
module tws_top_tb
  import tws_pkg::*;
;
  logic                  clk = 1'b0;
  logic                  srst = 1'b1;
  logic [TWS_ADDR_W-1:0] addr = '0;
  logic                  rd_s = 1'b0;
  logic                  wr_s = 1'b0;
  logic [31:0]           wdata = '0;
  logic [31:0]           rdata;
  logic                  wreq;
  logic                  done;
  logic                  ext_sck;
  logic                  peer_so;
  logic                  ext_q = 1'b0;
  logic                  lsb_q = 1'b0;
  logic [7:0]            p_out;
  logic [7:0]            p_oe;
  logic [7:0]            peer_tx = 8'h00;
  logic [7:0]            peer_rx;
  logic                  sck_prev = 1'b0;
  int                    num_errors = 0;
  int                    samples_checked = 0;
  int                    cyc = 0;
  int                    last_rise = 0;
  int                    per = 0;

  always #4 clk = ~clk;

  tws_top tws_top_i (
    .clk                    (clk),
    .srst                   (srst),
    .avs_address            (addr),
    .avs_read               (rd_s),
    .avs_write              (wr_s),
    .avs_writedata          (wdata),
    .avs_byteenable         (4'hF),
    .avs_readdata           (rdata),
    .avs_waitrequest        (wreq),
    .serial_clock_pin_i     (ext_sck),
    .serial_data_in_pin_i   (peer_so),
    .port1_out              (p_out),
    .port1_oe               (p_oe),
    .transfer_done_irq_flag (done)
  );
  tws_peer tws_peer_i (
    .dev_sck  (p_out[TWS_PIN_SCK]),
    .dev_so   (p_out[TWS_PIN_SO]),
    .ext_mode (ext_q),
    .lsb      (lsb_q),
    .tx       (peer_tx),
    .ext_sck  (ext_sck),
    .so       (peer_so),
    .rx       (peer_rx)
  );

  // Cycles between the last two rising edges of the master clock.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sck_prev <= p_out[TWS_PIN_SCK];
    if (p_out[TWS_PIN_SCK] && !sck_prev) begin
      per <= cyc - last_rise;
      last_rise <= cyc;
    end
  end

  function automatic int exp_per(input logic [2:0] s);
    return 2 << s;
  endfunction

  task automatic tally_and_finish();
    $display("Errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [15:0] i,
                     input logic [7:0] d, output logic [7:0] q);
    int k;
    @(posedge clk);
    addr <= {i, 2'b00};
    wdata <= {24'h000000, d};
    if (w) wr_s <= 1'b1;
    else rd_s <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    q = rdata[7:0];
    if (!w) `CHK(rdata[31:8], 24'h000000)
    if (k == 100) begin
      num_errors++;
      tally_and_finish();
    end
    rd_s <= 1'b0;
    wr_s <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, i, d, q);
  endtask

  task automatic rdc(input logic [15:0] i, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, i, 8'h00, q);
    `CHK(q, e)
  endtask

  task automatic wait_done();
    int k;
    for (k = 0; k < 5000; k++) begin
      @(posedge clk);
      if (done === 1'b1) break;
    end
    if (k == 5000) begin
      num_errors++;
      tally_and_finish();
    end
    wr(TWS_IDX_STATUS, 8'h01);
  endtask

  task automatic cfg(input logic [2:0] src, input logic tr, input logic lsb);
    ext_q = (src == TWS_SRC_EXT);
    lsb_q = lsb;
    wr(TWS_IDX_MODE, 8'h00);
    wr(TWS_IDX_PORT1_DIR, ext_q ? 8'hFB : 8'hFA);
    wr(TWS_IDX_CLK_SEL, {5'h00, src});
    wr(TWS_IDX_MODE, {1'b0, tr, 1'b0, lsb, 4'h0});
    wr(TWS_IDX_MODE, {1'b1, tr, 1'b0, lsb, 4'h0});
    peer_tx = 8'($urandom);
    // Below divide-by-16 the master samples before the synchronised input
    // settles, so the far side holds one level through the frame there.
    if (src < 3'h3) peer_tx = {8{peer_tx[0]}};
    tws_peer_i.sync(lsb ? peer_tx[0] : peer_tx[7]);
    repeat (8) @(posedge clk);
  endtask

  task automatic xfer(input logic [2:0] src, input logic lsb, input int half);
    logic [7:0] d;
    d = 8'($urandom);
    cfg(src, 1'b1, lsb);
    wr(TWS_IDX_TX_BUF, d);
    if (ext_q) tws_peer_i.frame(half);
    wait_done();
    rdc(TWS_IDX_SHIFT, peer_tx);
    `CHK(peer_rx, d)
    `CHK(p_out[TWS_PIN_SO], lsb ? d[7] : d[0])
    if (!ext_q) `CHK(per, exp_per(src))
  endtask

  initial begin
    logic [7:0] q;
    void'($urandom(26));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rdc(TWS_IDX_PORT1_DIR, 8'hFF);
    rdc(TWS_IDX_MODE, 8'h00);
    rdc(TWS_IDX_CLK_SEL, 8'h00);
    `CHK(p_oe, 8'h00)
    rdc(16'h0123, 8'h00);
    wr(TWS_IDX_MODE, 8'h3E);
    rdc(TWS_IDX_MODE, 8'h10);
    wr(TWS_IDX_CLK_SEL, 8'hFF);
    rdc(TWS_IDX_CLK_SEL, 8'h1F);
    q = 8'($urandom);
    wr(TWS_IDX_PORT1_LATCH, q);
    wr(TWS_IDX_PORT1_DIR, q);
    repeat (2) @(posedge clk);
    `CHK(p_out[7:1], q[7:1])
    `CHK(p_oe, ~q)
    wr(TWS_IDX_PORT1_LATCH, 8'h01);
    for (int i = 0; i < 8; i++) xfer(3'(i), i[0], 120);
    xfer(TWS_SRC_EXT, 1'b0, 96);
    wr(TWS_IDX_PORT1_LATCH, 8'h05);
    cfg(3'h1, 1'b0, 1'b1);
    bus(1'b0, TWS_IDX_SHIFT, 8'h00, q);
    wait_done();
    `CHK(p_out[TWS_PIN_SO], 1'b1)
    rdc(TWS_IDX_SHIFT, peer_tx);
    wait_done();
    wr(TWS_IDX_PORT1_LATCH, 8'h01);
    cfg(3'h6, 1'b1, 1'b0);
    wr(TWS_IDX_TX_BUF, 8'($urandom));
    rdc(TWS_IDX_MODE, 8'hC1);
    wr(TWS_IDX_MODE, 8'h40);
    rdc(TWS_IDX_MODE, 8'h40);
    rdc(TWS_IDX_SHIFT, 8'h00);
    `CHK(done, 1'b0)
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rdc(TWS_IDX_PORT1_DIR, 8'hFF);
    tally_and_finish();
  end
endmodule
`default_nettype wire
